// ---- fds_pkg.sv ----
package fds_pkg;
  // system clock period
  localparam int CLK_PERIOD_NS = 10;

  // drive-side intervals at the fast rate, in ns; the slow rate doubles all but the shortfall
  localparam int T_SEL_SETUP_NS = 12000;
  localparam int T_SEEK_SETUP_NS = 7000;
  localparam int T_DIR_SETUP_NS = 1000;
  localparam int T_STEP_MIN_NS = 6000;
  localparam int T_STEP_TYP_NS = 7000;
  localparam int T_STEP_MAX_NS = 8000;
  localparam int T_SEL_HOLD_STEP_NS = 5000;
  localparam int T_STEP_CYCLE_NS = 33000;
  localparam int T_DIR_HOLD_NS = 24000;
  localparam int T_SEEK_HOLD_NS = 30000;
  localparam int T_SEL_HOLD_SEEK_NS = 15000;
  localparam int T_DRIVE_FAULT_RESET_MIN_NS = 8000;
  localparam int T_DRIVE_FAULT_RESET_TYP_NS = 9000;
  localparam int T_DRIVE_FAULT_RESET_MAX_NS = 10000;
  localparam int T_SHORTFALL_NS = 50;

  // least times round up, longest times round down
  localparam int C_SEL_SETUP = (T_SEL_SETUP_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam int C_SEEK_SETUP = (T_SEEK_SETUP_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int C_DIR_SETUP = (T_DIR_SETUP_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam int C_STEP_MIN = (T_STEP_MIN_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  localparam int C_STEP_TYP = T_STEP_TYP_NS / CLK_PERIOD_NS;
  localparam int C_STEP_MAX = T_STEP_MAX_NS / CLK_PERIOD_NS;
  localparam int C_SEL_HOLD_STEP = (T_SEL_HOLD_STEP_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int C_STEP_LOW = (T_STEP_CYCLE_NS - T_STEP_TYP_NS
                               + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_DIR_HOLD = (T_DIR_HOLD_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  localparam int C_SEEK_HOLD = (T_SEEK_HOLD_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam int C_SEL_HOLD_SEEK = (T_SEL_HOLD_SEEK_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int C_DRIVE_FAULT_RESET_MIN = (T_DRIVE_FAULT_RESET_MIN_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  localparam int C_DRIVE_FAULT_RESET_TYP = T_DRIVE_FAULT_RESET_TYP_NS / CLK_PERIOD_NS;
  localparam int C_DRIVE_FAULT_RESET_MAX = T_DRIVE_FAULT_RESET_MAX_NS / CLK_PERIOD_NS;
  localparam int C_SHORTFALL = (T_SHORTFALL_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;

  localparam int TIMER_W = 14;
  localparam int STEP_CNT_W = 8;

  // version answer, value is arbitrary
  localparam logic [7:0] VERSION_ID_DEFAULT = 8'h5a;

  typedef struct packed {
    logic [1:0] unit;
    logic dir;
    logic [STEP_CNT_W-1:0] steps;
  } fds_seek_cmd_t;

  typedef struct packed {
    logic drive_select_bit1;
    logic drive_select_bit0;
    logic seek_mode;
    logic step_dir;
    logic step;
    logic drive_fault_reset;
  } fds_drive_pins_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SEL_SET, ST_SEEK_SET, ST_DIR_SET, ST_STEP_HI, ST_STEP_LO,
    ST_DIR_HOLD, ST_SEEK_HOLD, ST_SEL_HOLD, ST_DRIVE_FAULT_RESET
  } fds_state_t;
endpackage : fds_pkg

// ---- fds_sequencer.sv ----
`timescale 1ns/1ps
// Overview of operation
// - drive select stable 12/24 us before seek mode rises
// - seek mode high 7/14 us before step direction is set
// - step direction settled 1/2 us before a step pulse rises
// - step pulse high 6 to 8 us, typically 7; doubled at slow rate
// - drive select unchanged 5/10 us after a step pulse ends
// - step direction unchanged 24/48 us after the last step pulse
// - seek mode kept 30/60 us after step direction is released
// - drive select unchanged 15/30 us after seek mode falls
// - fault reset pulse high 8 to 10 us, or 16 to 20 us
// - every least time may fall short by 50 ns under test
// - enhanced variant flags every overrun, final byte included
// - enhanced variant drops dma request before result phase on overrun
// - write clock may be unrelated to the system clock
// - version query returns an identifying first result status byte
module fds_sequencer #(
  parameter bit ENHANCED = 1'b1,
  parameter logic [7:0] VERSION_ID = fds_pkg::VERSION_ID_DEFAULT
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic slow_rate_i,
  input wire logic seek_start_i,
  input wire fds_pkg::fds_seek_cmd_t seek_cmd_i,
  input wire logic fault_reset_start_i,
  input wire logic dma_want_i,
  input wire logic overrun_i,
  input wire logic last_byte_i,
  input wire logic result_entry_i,
  input wire logic status_clear_i,
  input wire logic version_query_i,
  input wire logic dma_acknowledge_n_i,
  input wire logic write_clk_i,
  output fds_pkg::fds_drive_pins_t drive_o,
  output logic busy_o,
  output logic dma_request_o,
  output logic overrun_flag_o,
  output logic [7:0] first_result_status_o,
  output logic write_clk_sync_o
);
  import fds_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  fds_state_t state, next_state;
  logic [TIMER_W-1:0] timer;
  logic [STEP_CNT_W-1:0] steps_left;
  logic [1:0] unit;
  logic dir;
  logic slow;
  logic [TIMER_W-1:0] dur_base;

  wire timer_done = (timer == '0);
  wire state_move = (next_state != state);
  wire idle_accept_seek = (state == ST_IDLE) && seek_start_i;
  wire idle_accept_drive_fault_reset = (state == ST_IDLE) && !seek_start_i
                          && fault_reset_start_i;
  wire last_step = (steps_left == STEP_CNT_W'(1));
  // the first interval loads on the accepting edge, before slow is caught
  wire slow_now = (state == ST_IDLE) ? slow_rate_i : slow;
  // slow rate doubles every count, it is never a separate table
  wire [TIMER_W-1:0] dur_scaled = slow_now ? {dur_base[TIMER_W-2:0], 1'b0}
                                           : dur_base;
  wire [TIMER_W-1:0] dur_load = dur_scaled - TIMER_W'(1);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (seek_start_i) next_state = ST_SEL_SET;
        else if (fault_reset_start_i) next_state = ST_DRIVE_FAULT_RESET;
      end
      ST_SEL_SET: if (timer_done) next_state = ST_SEEK_SET;
      ST_SEEK_SET: if (timer_done) next_state = ST_DIR_SET;
      ST_DIR_SET: begin
        if (timer_done) begin
          next_state = (steps_left == '0) ? ST_DIR_HOLD : ST_STEP_HI;
        end
      end
      ST_STEP_HI: begin
        if (timer_done) next_state = last_step ? ST_DIR_HOLD : ST_STEP_LO;
      end
      ST_STEP_LO: if (timer_done) next_state = ST_STEP_HI;
      ST_DIR_HOLD: if (timer_done) next_state = ST_SEEK_HOLD;
      ST_SEEK_HOLD: if (timer_done) next_state = ST_SEL_HOLD;
      ST_SEL_HOLD: if (timer_done) next_state = ST_IDLE;
      ST_DRIVE_FAULT_RESET: if (timer_done) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_comb begin
    case (next_state)
      ST_SEL_SET: dur_base = TIMER_W'(C_SEL_SETUP);
      ST_SEEK_SET: dur_base = TIMER_W'(C_SEEK_SETUP);
      ST_DIR_SET: dur_base = TIMER_W'(C_DIR_SETUP);
      ST_STEP_HI: dur_base = TIMER_W'(C_STEP_TYP);
      ST_STEP_LO: dur_base = TIMER_W'(C_STEP_LOW);
      ST_DIR_HOLD: dur_base = TIMER_W'(C_DIR_HOLD);
      ST_SEEK_HOLD: dur_base = TIMER_W'(C_SEEK_HOLD);
      ST_SEL_HOLD: dur_base = TIMER_W'(C_SEL_HOLD_SEEK);
      ST_DRIVE_FAULT_RESET: dur_base = TIMER_W'(C_DRIVE_FAULT_RESET_TYP);
      default: dur_base = TIMER_W'(1);
    endcase
  end

  // rate is caught only while idle so no interval changes mid-sequence
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      slow <= 1'b0;
      unit <= 2'h0;
      dir <= 1'b0;
    end else if (idle_accept_seek) begin
      slow <= slow_rate_i;
      unit <= seek_cmd_i.unit;
      dir <= seek_cmd_i.dir;
    end else if (idle_accept_drive_fault_reset) begin
      slow <= slow_rate_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      timer <= '0;
    end else begin
      state <= next_state;
      if (state_move) timer <= dur_load;
      else if (!timer_done) timer <= timer - TIMER_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) steps_left <= '0;
    else if (idle_accept_seek) steps_left <= seek_cmd_i.steps;
    else if (state == ST_STEP_HI && timer_done)
      steps_left <= steps_left - STEP_CNT_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////
  // pins are decoded from next_state so each registered edge lands with
  // the state change and the timer window lines up exactly
  wire seek_on = (next_state inside {ST_SEEK_SET, ST_DIR_SET, ST_STEP_HI,
                  ST_STEP_LO, ST_DIR_HOLD, ST_SEEK_HOLD});
  wire dir_on = (next_state inside {ST_DIR_SET, ST_STEP_HI, ST_STEP_LO,
                 ST_DIR_HOLD});
  wire step_on = (next_state == ST_STEP_HI);
  wire drive_fault_reset_on = (next_state == ST_DRIVE_FAULT_RESET);
  // select moves only on leaving idle, so all holds come from the states
  wire [1:0] next_sel = idle_accept_seek ? seek_cmd_i.unit : unit;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      drive_o <= '0;
      busy_o <= 1'b0;
    end else begin
      drive_o.drive_select_bit1 <= next_sel[1];
      drive_o.drive_select_bit0 <= next_sel[0];
      drive_o.seek_mode <= seek_on;
      drive_o.step_dir <= dir_on & (idle_accept_seek ? seek_cmd_i.dir : dir);
      drive_o.step <= step_on;
      drive_o.drive_fault_reset <= drive_fault_reset_on;
      busy_o <= (next_state != ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // dma acknowledge and write clock are pins, two flops before use, plus a third flop on the write clock output
  logic [1:0] dma_acknowledge_sync;
  logic [1:0] wclk_sync;
  logic ovr_pending;
  wire dma_acknowledge_seen = !dma_acknowledge_sync[1];
  wire ovr_counts = overrun_i && (ENHANCED || !last_byte_i);
  wire dma_withdraw = ENHANCED && ovr_pending && result_entry_i;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dma_acknowledge_sync <= 2'h3;
      wclk_sync <= 2'h0;
      write_clk_sync_o <= 1'b0;
    end else begin
      dma_acknowledge_sync <= {dma_acknowledge_sync[0], dma_acknowledge_n_i};
      wclk_sync <= {wclk_sync[0], write_clk_i};
      write_clk_sync_o <= wclk_sync[1];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ovr_pending <= 1'b0;
      overrun_flag_o <= 1'b0;
      dma_request_o <= 1'b0;
      first_result_status_o <= 8'h00;
    end else begin
      // set wins over clear
      if (overrun_i) ovr_pending <= 1'b1;
      // a flag clear must not cancel the pending withdrawal
      else if (result_entry_i) ovr_pending <= 1'b0;
      if (ovr_counts) overrun_flag_o <= 1'b1;
      else if (status_clear_i) overrun_flag_o <= 1'b0;
      // withdrawal before the result phase outranks a fresh request
      if (dma_withdraw) dma_request_o <= 1'b0;
      else if (dma_want_i) dma_request_o <= 1'b1;
      else if (dma_acknowledge_seen) dma_request_o <= 1'b0;
      if (version_query_i) first_result_status_o <= VERSION_ID;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // helper ages: cycles each pin has held its level, saturating
  localparam int NW = 6;
  logic [NW-1:0] pins_now, pins_prev;
  logic [TIMER_W-1:0] age [NW];
  assign pins_now = drive_o;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) pins_prev <= '0;
    else pins_prev <= pins_now;
  end
  for (genvar g = 0; g < NW; g++) begin : g_age
    always_ff @(posedge sys_clk_i) begin
      // out of reset the pins count as long settled, no false short hold
      if (rst_i) age[g] <= '1;
      else if (pins_now[g] != pins_prev[g]) age[g] <= '0;
      else if (age[g] != '1) age[g] <= age[g] + TIMER_W'(1);
    end
  end
  // index: 5,4 select, 3 seek, 2 dir, 1 step, 0 fault reset
  function automatic int lim(input int c, input logic s);
    lim = (s ? 2 * c : c) - C_SHORTFALL - 1;
  endfunction

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_sel_before_seek: assert property ($rose(drive_o.seek_mode) |->
    $past(age[4]) >= lim(C_SEL_SETUP, slow)
    && $past(age[5]) >= lim(C_SEL_SETUP, slow))
    else $error("select not settled before seek mode");
  a_seek_before_dir: assert property (drive_o.step_dir != pins_prev[2]
    |-> $past(age[3]) >= lim(C_SEEK_SETUP, slow) && drive_o.seek_mode)
    else $error("seek mode too late before direction");
  a_dir_before_step: assert property ($rose(drive_o.step) |->
    $past(age[2]) >= lim(C_DIR_SETUP, slow) && drive_o.seek_mode)
    else $error("direction too late before step");
  a_step_width: assert property ($fell(drive_o.step) |->
    $past(age[1]) >= lim(C_STEP_MIN, slow)
    && $past(age[1]) < (slow ? 2 * C_STEP_MAX : C_STEP_MAX))
    else $error("step pulse width out of range");
  a_sel_after_step: assert property ($changed(pins_now[5:4])
    |-> !drive_o.step && $past(age[1]) >= lim(C_SEL_HOLD_STEP, $past(slow)))
    else $error("select moved too soon after step");
  a_dir_after_step: assert property ($fell(dir_on) |->
    age[1] >= lim(C_DIR_HOLD, slow))
    else $error("direction released too soon after step");
  a_seek_after_dir: assert property ($fell(drive_o.seek_mode) |->
    $past(age[2]) >= lim(C_SEEK_HOLD, slow))
    else $error("seek mode dropped too soon");
  a_sel_after_seek: assert property ($changed(pins_now[5:4])
    |-> $past(age[3]) >= lim(C_SEL_HOLD_SEEK, $past(slow)))
    else $error("select moved too soon after seek mode");
  a_drive_fault_reset_width: assert property ($fell(drive_o.drive_fault_reset) |->
    $past(age[0]) >= lim(C_DRIVE_FAULT_RESET_MIN, slow)
    && $past(age[0]) < (slow ? 2 * C_DRIVE_FAULT_RESET_MAX : C_DRIVE_FAULT_RESET_MAX))
    else $error("fault reset width out of range");
  a_ovr_flag: assert property (ovr_counts |=> overrun_flag_o)
    else $error("overrun not flagged");
  sequence s_ovr_then_result;
    (ENHANCED && overrun_i) ##[1:1000] (result_entry_i && !overrun_i);
  endsequence
  a_dma_withdraw: assert property (s_ovr_then_result
    |=> !dma_request_o)
    else $error("dma request kept into result phase");
  a_version_id: assert property (version_query_i |=>
    (first_result_status_o == VERSION_ID) [*2] or
    ((first_result_status_o == VERSION_ID) ##1 version_query_i))
    else $error("version answer wrong");
endmodule : fds_sequencer

// ---- fds_drive_model.sv ----
`timescale 1ns/1ps
module fds_drive_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire fds_pkg::fds_drive_pins_t drive_i,
  output logic [3:0][7:0] tracks_o,
  output logic misstep_o
);
  import fds_pkg::*;
  logic step_q;
  logic [1:0] unit;
  assign unit = {drive_i.drive_select_bit1, drive_i.drive_select_bit0};
  ////////////////////////////////////////////////////////////////////////////
  // head moves on the rising step edge only, like a real stepper
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tracks_o <= '0;
      step_q <= 1'h0;
      misstep_o <= 1'h0;
    end else begin
      step_q <= drive_i.step;
      if (drive_i.step && !step_q) begin
        if (drive_i.step_dir) tracks_o[unit] <= tracks_o[unit] + 8'h01;
        else tracks_o[unit] <= tracks_o[unit] - 8'h01;
        // a step outside seek mode would be lost by the drive
        if (!drive_i.seek_mode) misstep_o <= 1'h1;
      end
    end
  end
endmodule : fds_drive_model

// ---- tb_floppy_drive_side_sequencer.sv ----
`timescale 1ns/1ps
module tb_floppy_drive_side_sequencer;
  import fds_pkg::*;
  logic sys_clk_i = 1'h0, rst_i = 1'h1, slow_rate_i = 1'h0;
  logic seek_start_i = 1'h0, fault_reset_start_i = 1'h0;
  fds_seek_cmd_t seek_cmd_i = '0;
  logic dma_want_i = 1'h0, overrun_i = 1'h0, last_byte_i = 1'h0;
  logic result_entry_i = 1'h0, status_clear_i = 1'h0;
  logic version_query_i = 1'h0, dma_acknowledge_n_i = 1'h1;
  logic write_clk_i = 1'h0;
  fds_drive_pins_t drive_o;
  logic busy_o, dma_request_o, overrun_flag_o, write_clk_sync_o, misstep;
  logic [7:0] first_result_status_o;
  logic [3:0][7:0] tracks;
  int fail_count = 0, checked = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  // odd period keeps the write clock drifting against the system clock
  always #23.7 write_clk_i = ~write_clk_i;
  fds_sequencer dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .slow_rate_i(slow_rate_i), .seek_start_i(seek_start_i),
    .seek_cmd_i(seek_cmd_i), .fault_reset_start_i(fault_reset_start_i),
    .dma_want_i(dma_want_i), .overrun_i(overrun_i), .last_byte_i(last_byte_i),
    .result_entry_i(result_entry_i), .status_clear_i(status_clear_i),
    .version_query_i(version_query_i),
    .dma_acknowledge_n_i(dma_acknowledge_n_i), .write_clk_i(write_clk_i),
    .drive_o(drive_o), .busy_o(busy_o), .dma_request_o(dma_request_o),
    .overrun_flag_o(overrun_flag_o),
    .first_result_status_o(first_result_status_o),
    .write_clk_sync_o(write_clk_sync_o));
  fds_drive_model model_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .drive_i(drive_o), .tracks_o(tracks), .misstep_o(misstep));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  //////////////////////////////////////////////////////////////////////////
  task automatic run_seek(input logic [1:0] u, input logic d,
                          input logic [7:0] n, input logic slow);
    int t = 0, m, nsel = 0, nst = 0, tsel = 0, tsk = 0, tdr = 0, tst = 0;
    int tsl = 0, tsf = 0, tdf = 0, tkf = 0;
    logic [7:0] trk0;
    logic [7:0] trk_exp;
    fds_drive_pins_t p;
    m = slow ? 2 : 1;
    trk0 = tracks[u];
    slow_rate_i = slow;
    seek_cmd_i = '{unit: u, dir: d, steps: n};
    // select moves on the accepting edge, so compare against before it
    p = drive_o;
    seek_start_i = 1'h1;
    @(negedge sys_clk_i);
    seek_start_i = 1'h0;
    seek_cmd_i.unit = ~u;
    while ((t == 0 || busy_o === 1'h1) && t < 40000) begin
      if ({drive_o.drive_select_bit1, drive_o.drive_select_bit0} !==
          {p.drive_select_bit1, p.drive_select_bit0}) begin
        nsel++;
        tsel = t;
      end
      if (drive_o.seek_mode && !p.seek_mode) tsk = t;
      if (!drive_o.seek_mode && p.seek_mode) tkf = t;
      if (drive_o.step_dir && !p.step_dir) tdr = t;
      if (!drive_o.step_dir && p.step_dir) tdf = t;
      if (drive_o.step && !p.step) begin
        if (nst == 0) tst = t;
        tsl = t;
        nst++;
      end
      if (!drive_o.step && p.step) tsf = t;
      p = drive_o;
      @(negedge sys_clk_i);
      t++;
      // a start while busy must be ignored
      seek_start_i = (t == 100);
    end
    chk("seek done", busy_o, 0);
    chk("select changes", nsel, 1);
    chk("select value", {drive_o.drive_select_bit1,
        drive_o.drive_select_bit0}, u);
    chk("select to seek", tsk - tsel, 1200 * m);
    chk("step count", nst, n);
    // track counter wraps at eight bits like the model's
    trk_exp = d ? trk0 + n : trk0 - n;
    chk("track", tracks[u], trk_exp);
    chk("seek off to idle", t - tkf, 1500 * m);
    chk("misstep", misstep, 0);
    if (n != 0) begin
      chk("step high", tsf - tsl, 700 * m);
      chk("step spacing", tsl - tst, (n - 1) * 3300 * m);
    end
    if (n != 0 && d) begin
      chk("seek to dir", tdr - tsk, 700 * m);
      chk("dir to step", tst - tdr, 100 * m);
      chk("last step to dir off", tdf - tsf, 2400 * m);
      chk("dir off to seek off", tkf - tdf, 3000 * m);
    end
  endtask : run_seek
  task automatic run_fault(input logic slow);
    int w = 0, m;
    m = slow ? 2 : 1;
    slow_rate_i = slow;
    fault_reset_start_i = 1'h1;
    @(negedge sys_clk_i);
    fault_reset_start_i = 1'h0;
    while (drive_o.drive_fault_reset === 1'h1 && w < 5000) begin
      w++;
      @(negedge sys_clk_i);
    end
    chk("fault reset width", w, 900 * m);
    chk("fault width range", w >= 800 * m - 5 && w <= 1000 * m, 1);
    chk("idle after fault", busy_o, 0);
  endtask : run_fault
  task automatic pulse(ref logic s);
    s = 1'h1;
    @(negedge sys_clk_i);
    s = 1'h0;
  endtask : pulse
  task automatic run_dma();
    pulse(dma_want_i);
    chk("dma request", dma_request_o, 1);
    last_byte_i = 1'h1;
    pulse(overrun_i);
    last_byte_i = 1'h0;
    chk("overrun final byte", overrun_flag_o, 1);
    repeat (3) @(negedge sys_clk_i);
    chk("dma held", dma_request_o, 1);
    pulse(result_entry_i);
    chk("dma withdrawn", dma_request_o, 0);
    pulse(status_clear_i);
    chk("flag cleared", overrun_flag_o, 0);
    pulse(dma_want_i);
    dma_acknowledge_n_i = 1'h0;
    repeat (4) @(negedge sys_clk_i);
    dma_acknowledge_n_i = 1'h1;
    chk("ack clears dma", dma_request_o, 0);
    pulse(version_query_i);
    chk("version", first_result_status_o, VERSION_ID_DEFAULT);
  endtask : run_dma
  task automatic run_wclk();
    int e = 0;
    logic q;
    q = write_clk_sync_o;
    repeat (1000) begin
      @(negedge sys_clk_i);
      if (write_clk_sync_o && !q) e++;
      q = write_clk_sync_o;
    end
    chk("write clock edges", e >= 209 && e <= 212, 1);
  endtask : run_wclk
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (10) @(negedge sys_clk_i);
    rst_i = 1'h0;
    run_seek(2'h2, 1'h1, 8'h02, 1'h0);
    run_seek(2'h1, 1'h1, 8'h01, 1'h1);
    run_seek(2'h3, 1'h0, 8'h01, 1'h0);
    run_seek(2'h0, 1'h1, 8'h00, 1'h0);
    run_fault(1'h0);
    run_fault(1'h1);
    run_dma();
    run_wclk();
    give_verdict();
  end
endmodule : tb_floppy_drive_side_sequencer
